/* shared/sample_regs_map.svh */
// Register offsets, reset values and scale figures of the sample output block.
// Assumes inclusion by bare name from design files.
`ifndef SAMPLE_REGS_MAP_SVH
`define SAMPLE_REGS_MAP_SVH
`define ADDR_PRESSURE_BYTE_LOWEST 7'h28
`define ADDR_PRESSURE_BYTE_MIDDLE 7'h29
`define ADDR_PRESSURE_BYTE_UPPER 7'h2A
`define ADDR_TEMPERATURE_BYTE_LOWER 7'h2B
`define ADDR_TEMPERATURE_BYTE_UPPER 7'h2C
`define ADDR_QUEUE_PRESSURE_LOWEST 7'h78
`define ADDR_QUEUE_PRESSURE_MIDDLE 7'h79
`define ADDR_QUEUE_PRESSURE_UPPER 7'h7A
`define ADDR_QUEUE_TEMPERATURE_LOWER 7'h7B
`define ADDR_QUEUE_TEMPERATURE_UPPER 7'h7C
`define SAMPLE_RESET_VALUE 8'h00
`define PRESSURE_COUNTS_PER_HPA 4096
`define TEMPERATURE_COUNTS_PER_DEGC 100
`define TRIM_WORDS 4
`endif

/* shared/sample_regs_pkg.sv */
// Types shared by the sample output block.
// Assumes no surroundings beyond a SystemVerilog compiler.
package sample_regs_pkg;
  typedef logic signed [23:0] pressure_t;
  typedef logic signed [15:0] temperature_t;
  typedef struct packed
  {
    pressure_t pressure;
    temperature_t temperature;
  } sample_set_s;
  typedef enum logic [1:0]
  {
    TRIM_IDLE = 2'b00,
    TRIM_LOAD = 2'b01,
    TRIM_DONE = 2'b10
  } trim_state_e;
endpackage

/* rtl/sample_holder.sv */
// Holds one whole sample set, replaced in a single edge.
// Assumes load is a one-cycle strobe: new set, access start or queue head latch.
`timescale 1ns/10ps
`default_nettype none
module sample_holder
(
  input wire logic clock, // System clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic load, // Capture strobe
  input wire sample_regs_pkg::sample_set_s sample_in, // New set
  output sample_regs_pkg::sample_set_s sample_out // Held set
);
  sample_regs_pkg::sample_set_s next_sample;
  always_comb
  begin
    next_sample = sample_out;
    if (load)
    begin
      next_sample = sample_in;
    end
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sample_out <= '0;
    end
    else
    begin
      sample_out <= next_sample;
    end
  end
endmodule // sample_holder
`default_nettype wire

/* rtl/trim_loader.sv */
// Copies factory trim words from non-volatile storage after reset.
// Assumes storage answers a read one cycle after its address.
`timescale 1ns/10ps
`default_nettype none
`include "sample_regs_map.svh"
module trim_loader #(
  parameter int WORDS = `TRIM_WORDS
)
(
  input wire logic clock, // System clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic [7:0] nvm_data, // Storage read data
  output logic [$clog2(WORDS)-1:0] nvm_addr, // Storage address
  output logic [8*WORDS-1:0] trim_words, // Working trim values
  output logic trim_done // Load finished
);
  initial
  begin
    if (WORDS < 2)
    begin
      $error("trim_loader needs at least two words");
    end
  end
  sample_regs_pkg::trim_state_e state;
  sample_regs_pkg::trim_state_e next_state;
  logic [$clog2(WORDS)-1:0] next_addr;
  logic [8*WORDS-1:0] next_words;
  logic pending;
  logic next_pending;
  always_comb
  begin
    next_state = state;
    next_addr = nvm_addr;
    next_words = trim_words;
    next_pending = 1'b0;
    case (state)
      sample_regs_pkg::TRIM_IDLE:
      begin
        next_state = sample_regs_pkg::TRIM_LOAD;
        next_pending = 1'b1;
      end
      sample_regs_pkg::TRIM_LOAD:
      begin
        if (pending)
        begin
          next_words[8*nvm_addr +: 8] = nvm_data;
          if (nvm_addr == ($clog2(WORDS))'(WORDS - 1))
          begin
            next_state = sample_regs_pkg::TRIM_DONE;
          end
          else
          begin
            next_addr = nvm_addr + 1'b1;
          end
        end
        else
        begin
          // Storage answers a cycle after the address moves
          next_pending = 1'b1;
        end
      end
      default:
      begin
        next_state = sample_regs_pkg::TRIM_DONE;
      end
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= sample_regs_pkg::TRIM_IDLE;
      nvm_addr <= '0;
      trim_words <= '0;
      pending <= 1'b0;
      trim_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      nvm_addr <= next_addr;
      trim_words <= next_words;
      pending <= next_pending;
      trim_done <= (next_state == sample_regs_pkg::TRIM_DONE);
    end
  end
endmodule // trim_loader
`default_nettype wire

/* rtl/sample_output_regs.sv */
// Sample output register block: live and queued sample bytes, trim load, ready flag.
// Assumes a serial front end that presents byte reads as address plus strobe.
// What this block does
// - Pressure is held as a signed 24-bit two's complement word.
// - Pressure bytes sit at 28h (low), 29h (middle) and 2Ah (high).
// - One hectopascal is 4096 counts of the pressure word.
// - Queued pressure uses the same encoding at 78h, 79h and 7Ah.
// - Temperature bytes sit at 2Bh (low) and 2Ch (high).
// - Temperature is a signed 16-bit word joined from its two bytes.
// - One degree Celsius is 100 counts of the temperature word.
// - Queued temperature uses the same encoding at 7Bh and 7Ch.
// - Trim values are copied from storage into working registers after power-on.
// - A ready flag rises whenever a new pressure and temperature set is stored.
// - Burst reads of the queued bytes advance the address and wrap 7Ch to 78h.
`timescale 1ns/10ps
`default_nettype none
`include "sample_regs_map.svh"
module sample_output_regs #(
  parameter int TRIM_COUNT = `TRIM_WORDS
)
(
  input wire logic clock, // System clock, 10 MHz
  input wire logic sys_rst, // Sync reset, high
  input wire logic sample_valid, // New set strobe
  input wire logic signed [23:0] pressure_in, // Pressure counts
  input wire logic signed [15:0] temperature_in, // Temperature counts
  input wire logic queue_enable, // Queued output enabled
  input wire logic queue_valid, // Queue head present
  input wire logic signed [23:0] queue_pressure_in, // Queue head pressure
  input wire logic signed [15:0] queue_temperature_in, // Queue head temperature
  input wire logic bus_start, // Start of a register access
  input wire logic [6:0] bus_addr, // Start address
  input wire logic bus_read, // Byte read strobe
  input wire logic bus_write, // Byte write strobe
  input wire logic [7:0] bus_wdata, // Write data
  input wire logic [7:0] nvm_data, // Trim storage data
  output logic [$clog2(TRIM_COUNT)-1:0] nvm_addr, // Trim storage address
  output logic [7:0] bus_rdata, // Read data
  output logic bus_rvalid, // Read data valid
  output logic queue_pop, // Advance queue head
  output logic sample_ready_pin, // Data-ready level
  output logic [8*TRIM_COUNT-1:0] trim_words, // Working trim values
  output logic trim_done // Trim load finished
);
  // Scale figures carried for software; the raw word is the count
  localparam int PRESSURE_SCALE = `PRESSURE_COUNTS_PER_HPA;
  localparam int TEMPERATURE_SCALE = `TEMPERATURE_COUNTS_PER_DEGC;
  initial
  begin
    if (PRESSURE_SCALE != 4096 || TEMPERATURE_SCALE != 100 || TRIM_COUNT < 2)
    begin
      $error("sample_output_regs: unsupported configuration");
    end
    if ((`ADDR_QUEUE_TEMPERATURE_UPPER - `ADDR_QUEUE_PRESSURE_LOWEST) != 7'h04)
    begin
      $error("sample_output_regs: queued window must be five bytes");
    end
    if ((`ADDR_TEMPERATURE_BYTE_UPPER - `ADDR_PRESSURE_BYTE_LOWEST) != 7'h04)
    begin
      $error("sample_output_regs: live window must be five bytes");
    end
  end

  sample_regs_pkg::sample_set_s live_in;
  sample_regs_pkg::sample_set_s live;
  sample_regs_pkg::sample_set_s queued_in;
  sample_regs_pkg::sample_set_s queued;
  logic live_load;
  logic queue_load;
  logic [6:0] addr;
  logic [6:0] next_addr;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_pop;
  logic next_ready;
  logic queue_loaded;
  logic next_queue_loaded;
  sample_regs_pkg::sample_set_s view_in;
  sample_regs_pkg::sample_set_s view;
  logic [7:0] read_byte;
  logic read_wraps;
  logic fresh;
  logic next_fresh;

  assign live_in.pressure = pressure_in;
  assign live_in.temperature = temperature_in;
  assign queued_in.pressure = queue_pressure_in;
  assign queued_in.temperature = queue_temperature_in;
  assign live_load = sample_valid;
  // Newest set is frozen at each access start so a burst never mixes sets
  assign view_in = live_load ? live_in : live;
  // Head latched once the source has had a cycle to answer the last advance
  assign queue_load = queue_enable && queue_valid && !queue_loaded && !queue_pop;

  sample_holder u_live
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(live_load),
    .sample_in(live_in),
    .sample_out(live)
  );

  sample_holder u_view
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(bus_start),
    .sample_in(view_in),
    .sample_out(view)
  );

  sample_holder u_queued
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(queue_load),
    .sample_in(queued_in),
    .sample_out(queued)
  );

  trim_loader #(
    .WORDS(TRIM_COUNT)
  ) u_trim
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .nvm_data(nvm_data),
    .nvm_addr(nvm_addr),
    .trim_words(trim_words),
    .trim_done(trim_done)
  );

  // Byte at the current access address; unmapped addresses read as zero
  always_comb
  begin
    read_byte = `SAMPLE_RESET_VALUE;
    read_wraps = 1'b0;
    if (addr == `ADDR_PRESSURE_BYTE_LOWEST)
    begin
      read_byte = view.pressure[7:0];
    end
    else if (addr == `ADDR_PRESSURE_BYTE_MIDDLE)
    begin
      read_byte = view.pressure[15:8];
    end
    else if (addr == `ADDR_PRESSURE_BYTE_UPPER)
    begin
      read_byte = view.pressure[23:16];
    end
    else if (addr == `ADDR_TEMPERATURE_BYTE_LOWER)
    begin
      read_byte = view.temperature[7:0];
    end
    else if (addr == `ADDR_TEMPERATURE_BYTE_UPPER)
    begin
      read_byte = view.temperature[15:8];
    end
    else if (addr == `ADDR_QUEUE_PRESSURE_LOWEST)
    begin
      read_byte = queued.pressure[7:0];
    end
    else if (addr == `ADDR_QUEUE_PRESSURE_MIDDLE)
    begin
      read_byte = queued.pressure[15:8];
    end
    else if (addr == `ADDR_QUEUE_PRESSURE_UPPER)
    begin
      read_byte = queued.pressure[23:16];
    end
    else if (addr == `ADDR_QUEUE_TEMPERATURE_LOWER)
    begin
      read_byte = queued.temperature[7:0];
    end
    else if (addr == `ADDR_QUEUE_TEMPERATURE_UPPER)
    begin
      read_byte = queued.temperature[15:8];
      read_wraps = 1'b1;
    end
  end

  // Access address and read answer
  always_comb
  begin
    next_addr = addr;
    next_rdata = `SAMPLE_RESET_VALUE;
    next_rvalid = 1'b0;
    if (bus_start)
    begin
      next_addr = bus_addr;
    end
    else if (bus_read)
    begin
      next_rvalid = 1'b1;
      next_rdata = read_byte;
      // Burst advance, queued window wraps to its first byte
      if (read_wraps)
      begin
        next_addr = `ADDR_QUEUE_PRESSURE_LOWEST;
      end
      else
      begin
        next_addr = addr + 7'h01;
      end
    end
    else if (bus_write)
    begin
      // Output bytes are read-only; only the address moves on
      next_addr = addr + 7'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      addr <= 7'h00;
      bus_rdata <= `SAMPLE_RESET_VALUE;
      bus_rvalid <= 1'b0;
    end
    else
    begin
      addr <= next_addr;
      bus_rdata <= next_rdata;
      bus_rvalid <= next_rvalid;
    end
  end

  // Queue head bookkeeping; the wrap read hands the head back to the source
  always_comb
  begin
    next_queue_loaded = queue_loaded;
    next_pop = 1'b0;
    if (queue_load)
    begin
      next_queue_loaded = 1'b1;
    end
    if (bus_read && !bus_start && read_wraps)
    begin
      next_pop = queue_loaded;
      next_queue_loaded = 1'b0;
    end
    // Turning the queue off drops the held head
    if (!queue_enable)
    begin
      next_queue_loaded = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      queue_pop <= 1'b0;
      queue_loaded <= 1'b0;
    end
    else
    begin
      queue_pop <= next_pop;
      queue_loaded <= next_queue_loaded;
    end
  end

  // Ready flag; a set that lands after the frozen view keeps it up
  always_comb
  begin
    next_ready = sample_ready_pin;
    next_fresh = fresh;
    if (bus_start)
    begin
      next_fresh = 1'b0;
    end
    else if (sample_valid)
    begin
      next_fresh = 1'b1;
    end
    if (bus_read && !bus_start && !fresh && addr == `ADDR_TEMPERATURE_BYTE_UPPER)
    begin
      next_ready = 1'b0;
    end
    // New set wins over the clearing read
    if (sample_valid)
    begin
      next_ready = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sample_ready_pin <= 1'b0;
      fresh <= 1'b0;
    end
    else
    begin
      sample_ready_pin <= next_ready;
      fresh <= next_fresh;
    end
  end
endmodule // sample_output_regs
`default_nettype wire

/* verif/sample_output_props.sv */
// Concurrent checks on the sample output register block ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module sample_output_props
(
  input wire logic clock, // System clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic sample_valid, // New set strobe
  input wire logic bus_start, // Access start
  input wire logic bus_read, // Read strobe
  input wire logic [7:0] bus_rdata, // Read data
  input wire logic bus_rvalid, // Read data valid
  input wire logic queue_pop, // Queue advance
  input wire logic sample_ready_pin, // Data-ready level
  input wire logic trim_done // Trim loaded
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence pop_end_s;
    bus_rvalid ##1 !queue_pop;
  endsequence
  a_read_answered: assert property (bus_read && !bus_start |=> bus_rvalid)
    else $error("read not answered next cycle");
  a_start_silent: assert property (bus_start |=> !bus_rvalid)
    else $error("read data after address start");
  a_idle_silent: assert property (!bus_read |=> !bus_rvalid)
    else $error("read data without a read");
  a_quiet_zero: assert property (!bus_rvalid |-> bus_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_ready_rises: assert property (sample_valid |=> sample_ready_pin)
    else $error("ready missing after new set");
  a_ready_holds: assert property (!sample_ready_pin && !sample_valid |=> !sample_ready_pin)
    else $error("ready rose without new set");
  a_ready_cleared: assert property ($fell(sample_ready_pin) |-> $past(bus_read) && !$past(sample_valid))
    else $error("ready fell without a read");
  a_pop_paired: assert property (queue_pop |-> pop_end_s)
    else $error("queue advance not paired with read");
  a_trim_kept: assert property (trim_done |=> trim_done)
    else $error("trim done dropped");
endmodule // sample_output_props
bind sample_output_regs sample_output_props props_i
(
  .clock(clock),
  .sys_rst(sys_rst),
  .sample_valid(sample_valid),
  .bus_start(bus_start),
  .bus_read(bus_read),
  .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid),
  .queue_pop(queue_pop),
  .sample_ready_pin(sample_ready_pin),
  .trim_done(trim_done)
);
`default_nettype wire

/* verif/trim_store_model.sv */
// Behavioural trim storage facing the block's trim loader.
// Assumes one byte per address, data one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module trim_store_model #(
  parameter int WORDS = 4
)
(
  input wire logic clock, // System clock
  input wire logic [$clog2(WORDS)-1:0] nvm_addr, // Read address
  output logic [7:0] nvm_data // Read data
);
  // Contents are arbitrary, unique per word
  always_ff @(posedge clock)
  begin
    nvm_data <= 8'hA0 + 8'(nvm_addr);
  end
endmodule // trim_store_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the sample output register block.
// Assumes the checker is bound by its own file.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_valid = 1'b0;
  logic queue_enable = 1'b0;
  logic queue_valid = 1'b0;
  logic bus_start = 1'b0;
  logic bus_read = 1'b0;
  logic bus_write = 1'b0;
  logic [6:0] bus_addr = 7'h00;
  logic [7:0] bus_wdata = 8'h00;
  sample_regs_pkg::sample_set_s live = '0;
  sample_regs_pkg::sample_set_s queued = '0;
  logic [7:0] nvm_data;
  logic [1:0] nvm_addr;
  logic [7:0] bus_rdata;
  logic bus_rvalid;
  logic queue_pop;
  logic sample_ready_pin;
  logic [31:0] trim_words;
  logic trim_done;
  sample_regs_pkg::pressure_t p;
  sample_regs_pkg::temperature_t t;
  logic [39:0] qw;
  int compares = 0;
  int mismatches = 0;
  sample_output_regs #(.TRIM_COUNT(4)) dut
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .sample_valid(sample_valid),
    .pressure_in(live.pressure),
    .temperature_in(live.temperature),
    .queue_enable(queue_enable),
    .queue_valid(queue_valid),
    .queue_pressure_in(queued.pressure),
    .queue_temperature_in(queued.temperature),
    .bus_start(bus_start),
    .bus_addr(bus_addr),
    .bus_read(bus_read),
    .bus_write(bus_write),
    .bus_wdata(bus_wdata),
    .nvm_data(nvm_data),
    .nvm_addr(nvm_addr),
    .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid),
    .queue_pop(queue_pop),
    .sample_ready_pin(sample_ready_pin),
    .trim_words(trim_words),
    .trim_done(trim_done)
  );
  trim_store_model #(.WORDS(4)) nvm_i
  (
    .clock(clock),
    .nvm_addr(nvm_addr),
    .nvm_data(nvm_data)
  );
  initial
    forever #50 clock = ~clock;
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic start(input logic [6:0] a);
    @(posedge clock);
    bus_start <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_start <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] exp);
    @(posedge clock);
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #1;
    chk({bus_rvalid, bus_rdata}, {1'b1, exp});
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_wdata <= d;
    @(posedge clock);
    bus_write <= 1'b0;
    #1;
    chk(bus_rvalid, 1'b0);
  endtask
  initial
  begin
    repeat (3000) @(posedge clock);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
  initial
  begin
    p = 24'(1000 * 4096);
    t = 16'(-25 * 100);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 40 && trim_done !== 1'b1; i++)
      @(posedge clock);
    chk(trim_words, 32'hA3A2A1A0);
    chk(trim_done, 1'b1);
    chk(sample_ready_pin, 1'b0);
    @(posedge clock);
    live <= {p, t};
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    #1;
    chk(sample_ready_pin, 1'b1);
    start(7'h28);
    rd(p[7:0]);
    rd(p[15:8]);
    rd(p[23:16]);
    rd(t[7:0]);
    rd(t[15:8]);
    @(posedge clock);
    #1;
    chk(sample_ready_pin, 1'b0);
    start(7'h28);
    wr(8'hFF);
    start(7'h28);
    rd(p[7:0]);
    start(7'h28);
    rd(p[7:0]);
    @(posedge clock);
    live <= {~p, ~t};
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    rd(p[15:8]);
    rd(p[23:16]);
    rd(t[7:0]);
    rd(t[15:8]);
    @(posedge clock);
    #1;
    chk(sample_ready_pin, 1'b1);
    start(7'h2B);
    rd(~t[7:0]);
    rd(~t[15:8]);
    @(posedge clock);
    #1;
    chk(sample_ready_pin, 1'b0);
    qw = {-t, -p};
    @(posedge clock);
    queued <= {-p, -t};
    queue_enable <= 1'b1;
    queue_valid <= 1'b1;
    start(7'h78);
    for (int i = 0; i < 5; i++)
    begin
      rd(qw[8 * i +: 8]);
      chk(queue_pop, (i == 4) ? 1'b1 : 1'b0);
    end
    @(posedge clock);
    queued <= {p, t};
    rd(p[7:0]);
    chk(queue_pop, 1'b0);
    start(7'h10);
    rd(8'h00);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
